// ### ppabc_pkg.sv
// Package with register map, field positions and reset values of ports A, B, C.
package ppabc_pkg;

    // APB address width in bits.
    localparam int ADDR_W = 12;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_SLAVE_PORT_CONTROL = 8'h24;
    localparam logic [7:0] IDX_PORT_A_DATA = 8'h30;
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h40;
    localparam logic [7:0] IDX_PORT_C_DATA = 8'h50;
    localparam logic [7:0] IDX_PORT_C_FUNCTION = 8'h55;

    // Byte addresses derived from the indices.
    localparam logic [11:0] ADDR_SLAVE_PORT_CONTROL =
        {2'b00, IDX_SLAVE_PORT_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_PORT_A_DATA = {2'b00, IDX_PORT_A_DATA, 2'b00};
    localparam logic [11:0] ADDR_PORT_B_DATA = {2'b00, IDX_PORT_B_DATA, 2'b00};
    localparam logic [11:0] ADDR_PORT_C_DATA = {2'b00, IDX_PORT_C_DATA, 2'b00};
    localparam logic [11:0] ADDR_PORT_C_FUNCTION =
        {2'b00, IDX_PORT_C_FUNCTION, 2'b00};

    // Slave port control fields.
    localparam int SPC_PORT_A_OUT_BIT = 2;
    localparam int SPC_SLAVE_EN_LSB = 0;
    localparam int SPC_SLAVE_EN_MSB = 1;
    localparam logic [7:0] SPC_RESET = 8'h00;

    // Slave port control values that select port A direction.
    localparam logic [7:0] SPC_PORT_A_INPUT = 8'h80;
    localparam logic [7:0] SPC_PORT_A_OUTPUT = 8'h84;

    // Port B layout.
    localparam int PB_CLK_B_BIT = 0;
    localparam int PB_CLK_A_BIT = 1;
    localparam int PB_SLAVE_LSB = 2;
    localparam int PB_OUT_LSB = 6;
    localparam logic [1:0] PB_OUT_RESET = 2'h0;

    // Port C layout: even bits drive, odd bits sense.
    localparam logic [7:0] PC_EVEN_MASK = 8'h55;
    localparam logic [7:0] PC_RESET = 8'h00;

endpackage : ppabc_pkg

// ### ppabc_bit_select.sv
// Per-bit selector between a stored output value and an alternate source.
`timescale 1ns/1ps
`default_nettype none

module ppabc_bit_select #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] sel, // High takes the alternate source.
    input wire logic [WIDTH-1:0] stored, // Value from the data register.
    input wire logic [WIDTH-1:0] alt, // Alternate function drive.
    output logic [WIDTH-1:0] drive // Resulting pin drive.
);

    // One multiplexer per bit; the stored value is ignored while selected.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign drive[i] = sel[i] ? alt[i] : stored[i];
        end
    endgenerate

endmodule : ppabc_bit_select

`default_nettype wire

// ### ppabc_ports.sv
// Parallel ports A, B and C with an APB register slave.
// How it works
// - After reset port A is an input with its drivers off.
// - Reading port A data returns the real pin levels, which may differ from the stored output.
// - Port B has inputs on bits 0 to 5 and outputs on bits 6 and 7, and writes to bits 0 to 5 do nothing.
// - With the slave port enabled, port B lines 2 to 7 belong to the slave port.
// - Port B bits 2 to 5 read the pins even while the slave port owns lines 2 to 7.
// - Port B bits 6 and 7 read the signal really driving those pins, slave drive included.
// - Port B bit 0 carries serial B clock and bit 1 serial A clock when their internal clocks run, else pin inputs.
// - Reset clears port B output bits 6 and 7 so both pins drive low.
// - Port C even bits are outputs, odd bits inputs; reads give pins for odd bits and drive for even bits.
// - A set port C function bit routes its serial transmitter to the pin and the stored data bit is ignored.
// - Port C input pins stay readable while also used as serial receive inputs.
// - Reset clears the even bits of port C data and function registers so the outputs drive zero.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module ppabc_ports (
    input wire logic clk, // 40 MHz system clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [ppabc_pkg::ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data, registered.
    output logic pready, // APB ready, always high.
    output logic pslverr, // APB error on unmapped address.
    input wire logic [7:0] portAIn, // Port A pin levels.
    output logic [7:0] portAOut, // Port A output register.
    output logic [7:0] portAOe, // Port A output enables.
    input wire logic [7:0] portBIn, // Port B pin levels.
    output logic [7:0] portBOut, // Port B pin drive.
    output logic [7:0] portBOe, // Port B output enables.
    input wire logic [5:0] slaveBDrive, // Slave port drive on lines 2 to 7.
    input wire logic [5:0] slaveBOe, // Slave port enables on lines 2 to 7.
    output logic slaveEnable, // Slave port enabled by control register.
    input wire logic serialAClk, // Serial A internal clock.
    input wire logic serialAClkEn, // Serial A internal clock enabled.
    input wire logic serialBClk, // Serial B internal clock.
    input wire logic serialBClkEn, // Serial B internal clock enabled.
    input wire logic [3:0] serialTx, // Transmitters D, C, B, A in bits 0..3.
    input wire logic [7:0] portCIn, // Port C pin levels.
    output logic [7:0] portCOut, // Port C pin drive, even bits meaningful.
    output logic [7:0] portCOe, // Port C output enables.
    output logic [3:0] serialRx // Receive inputs D, C, B, A from odd pins.
);

    // True when the bus address names the given register.
    function automatic logic regHit(input logic [ppabc_pkg::ADDR_W-1:0] a,
                                    input logic [11:0] target);
        regHit = (a == target[ppabc_pkg::ADDR_W-1:0]);
    endfunction : regHit

    logic [7:0] slavePortControl;
    logic [7:0] portAData;
    logic [1:0] portBData;
    logic [7:0] portCData;
    logic [7:0] portCFunction;
    logic [7:0] next_readData;
    logic setupPhase;
    logic writeAccess;
    logic mapped;
    logic [7:0] portCAlt;
    logic [7:0] portCDrive;
    logic [7:0] portBSel;
    logic [7:0] portBAlt;
    logic [7:0] portBStored;
    logic firstCycle;

    // Register decode shared by reads, writes and the error answer.
    assign setupPhase = psel && !penable;
    assign writeAccess = psel && penable && pwrite;
    assign mapped = regHit(paddr, ppabc_pkg::ADDR_SLAVE_PORT_CONTROL) ||
                    regHit(paddr, ppabc_pkg::ADDR_PORT_A_DATA) ||
                    regHit(paddr, ppabc_pkg::ADDR_PORT_B_DATA) ||
                    regHit(paddr, ppabc_pkg::ADDR_PORT_C_DATA) ||
                    regHit(paddr, ppabc_pkg::ADDR_PORT_C_FUNCTION);

    // No wait states: every access finishes in its first access cycle.
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Slave port control register; port A direction lives here.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            slavePortControl <= ppabc_pkg::SPC_RESET;
        end else if (writeAccess &&
                     regHit(paddr, ppabc_pkg::ADDR_SLAVE_PORT_CONTROL)) begin
            slavePortControl <= pwdata[7:0];
        end
    end

    // Port A output register; reset clears its contents to zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            portAData <= 8'h00;
        end else if (writeAccess &&
                     regHit(paddr, ppabc_pkg::ADDR_PORT_A_DATA)) begin
            portAData <= pwdata[7:0];
        end
    end

    // Port B keeps only bits 6 and 7; lower write bits are dropped.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            portBData <= ppabc_pkg::PB_OUT_RESET;
        end else if (writeAccess &&
                     regHit(paddr, ppabc_pkg::ADDR_PORT_B_DATA)) begin
            portBData <= pwdata[7:6];
        end
    end

    // Port C data and function keep even bits only; odd bits are inputs.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            portCData <= ppabc_pkg::PC_RESET;
            portCFunction <= ppabc_pkg::PC_RESET;
        end else if (writeAccess) begin
            if (regHit(paddr, ppabc_pkg::ADDR_PORT_C_DATA)) begin
                portCData <= pwdata[7:0] & ppabc_pkg::PC_EVEN_MASK;
            end
            if (regHit(paddr, ppabc_pkg::ADDR_PORT_C_FUNCTION)) begin
                portCFunction <= pwdata[7:0] & ppabc_pkg::PC_EVEN_MASK;
            end
        end
    end

    // Port A drives only when software has picked output direction.
    assign portAOut = portAData;
    assign portAOe = {8{slavePortControl[ppabc_pkg::SPC_PORT_A_OUT_BIT]}};
    assign slaveEnable = |slavePortControl[ppabc_pkg::SPC_SLAVE_EN_MSB:
                                           ppabc_pkg::SPC_SLAVE_EN_LSB];

    // Port B sources: serial clocks low, slave port on 2..7, data on 6..7.
    assign portBStored = {portBData, 6'h00};
    assign portBAlt = {slaveBDrive, serialAClk, serialBClk};
    assign portBSel = {{6{slaveEnable}}, serialAClkEn, serialBClkEn};

    ppabc_bit_select #(
        .WIDTH(8)
    ) u_portBSelect (
        .sel(portBSel),
        .stored(portBStored),
        .alt(portBAlt),
        .drive(portBOut)
    );

    // Outputs 6 and 7 drive unless the slave port is enabled; the lower lines only for a clock or slave.
    always_comb begin
        portBOe = 8'h00;
        portBOe[ppabc_pkg::PB_CLK_B_BIT] = serialBClkEn;
        portBOe[ppabc_pkg::PB_CLK_A_BIT] = serialAClkEn;
        portBOe[7:6] = 2'h3;
        if (slaveEnable) begin
            portBOe[7:2] = slaveBOe;
        end
    end

    // Port C transmitters: A on 6, B on 4, C on 2, D on 0.
    assign portCAlt = {1'b0, serialTx[3], 1'b0, serialTx[2],
                       1'b0, serialTx[1], 1'b0, serialTx[0]};

    ppabc_bit_select #(
        .WIDTH(8)
    ) u_portCSelect (
        .sel(portCFunction),
        .stored(portCData),
        .alt(portCAlt),
        .drive(portCDrive)
    );

    // Stored data is ignored on a bit whose function bit is set.
    assign portCOut = portCDrive & ppabc_pkg::PC_EVEN_MASK;
    assign portCOe = ppabc_pkg::PC_EVEN_MASK;
    // Odd pins feed the receivers and stay readable as well.
    assign serialRx = {portCIn[7], portCIn[5], portCIn[3], portCIn[1]};

    // Read mux; port A reads the pins, never the stored copy, so forcing shows.
    always_comb begin
        next_readData = 8'h00;
        if (regHit(paddr, ppabc_pkg::ADDR_SLAVE_PORT_CONTROL)) begin
            next_readData = slavePortControl;
        end else if (regHit(paddr, ppabc_pkg::ADDR_PORT_A_DATA)) begin
            next_readData = portAIn;
        end else if (regHit(paddr, ppabc_pkg::ADDR_PORT_B_DATA)) begin
            next_readData = {portBOut[7:6], portBIn[5:2],
                             portBSel[1] ? serialAClk : portBIn[1],
                             portBSel[0] ? serialBClk : portBIn[0]};
        end else if (regHit(paddr, ppabc_pkg::ADDR_PORT_C_DATA)) begin
            next_readData = (portCIn & ~ppabc_pkg::PC_EVEN_MASK) |
                            portCOut;
        end
    end

    // Read data is captured in the setup cycle so it stands in the access.
    // The write-only function register reads as zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
        end else if (setupPhase) begin
            prdata <= {24'h000000, next_readData};
        end
    end

    // High only in the first cycle after reset release; used by checks.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            firstCycle <= 1'b1;
        end else begin
            firstCycle <= 1'b0;
        end
    end

    // Bus write completion to a given register.
    sequence s_writeTo(logic [11:0] target);
        psel && penable && pwrite && paddr == target[ppabc_pkg::ADDR_W-1:0];
    endsequence

    // Read setup to a given register.
    sequence s_readSetup(logic [11:0] target);
        psel && !penable && !pwrite &&
        paddr == target[ppabc_pkg::ADDR_W-1:0];
    endsequence

    a_porta_dir_out: assert property (@(posedge clk) disable iff (!resetn)
        s_writeTo(ppabc_pkg::ADDR_SLAVE_PORT_CONTROL) ##0
        (pwdata[7:0] == ppabc_pkg::SPC_PORT_A_OUTPUT) |=>
        portAOe == 8'hFF)
        else $error("Port A did not turn to output after 0x84.");

    a_porta_dir_in: assert property (@(posedge clk) disable iff (!resetn)
        s_writeTo(ppabc_pkg::ADDR_SLAVE_PORT_CONTROL) ##0
        (pwdata[7:0] == ppabc_pkg::SPC_PORT_A_INPUT) |=>
        portAOe == 8'h00)
        else $error("Port A did not turn to input after 0x80.");

    a_reset_state: assert property (@(posedge clk) disable iff (!resetn)
        firstCycle |-> portAOe == 8'h00 && portBOut[7:6] == 2'h0 &&
        portCOut == 8'h00 && portCFunction == 8'h00 &&
        portCData == 8'h00)
        else $error("Outputs not in reset state after release.");

    a_porta_pins: assert property (@(posedge clk) disable iff (!resetn)
        s_readSetup(ppabc_pkg::ADDR_PORT_A_DATA) |=>
        prdata[7:0] == $past(portAIn) && penable)
        else $error("Port A read did not return pin levels.");

    a_portb_write: assert property (@(posedge clk) disable iff (!resetn)
        s_writeTo(ppabc_pkg::ADDR_PORT_B_DATA) |=>
        portBData == $past(pwdata[7:6]))
        else $error("Port B write did not land on bits 6 and 7.");

    a_portb_slave: assert property (@(posedge clk) disable iff (!resetn)
        slaveEnable |-> portBOut[7:2] == slaveBDrive &&
        portBOe[7:2] == slaveBOe)
        else $error("Slave port does not own port B lines 2 to 7.");

    a_portb_read: assert property (@(posedge clk) disable iff (!resetn)
        s_readSetup(ppabc_pkg::ADDR_PORT_B_DATA) |=>
        prdata[5:2] == $past(portBIn[5:2]) &&
        prdata[7:6] == $past(portBOut[7:6]))
        else $error("Port B read lost pins or echo drive.");

    a_portb_clock: assert property (@(posedge clk) disable iff (!resetn)
        serialBClkEn && !serialAClkEn |->
        portBOut[0] == serialBClk && portBOe[1:0] == 2'b01)
        else $error("Serial B clock not on port B bit 0.");

    a_portc_func: assert property (@(posedge clk) disable iff (!resetn)
        portCFunction[6] |-> portCOut[6] == serialTx[3])
        else $error("Serial A transmitter not routed to port C bit 6.");

    a_portc_read: assert property (@(posedge clk) disable iff (!resetn)
        s_readSetup(ppabc_pkg::ADDR_PORT_C_DATA) |=>
        (prdata[7:0] & ~ppabc_pkg::PC_EVEN_MASK) ==
        ($past(portCIn) & ~ppabc_pkg::PC_EVEN_MASK) &&
        (prdata[7:0] & ppabc_pkg::PC_EVEN_MASK) == $past(portCOut))
        else $error("Port C read mixed up pins and drive.");

    a_porta_write: assert property (@(posedge clk) disable iff (!resetn)
        s_writeTo(ppabc_pkg::ADDR_PORT_A_DATA) |=>
        portAOut == $past(pwdata[7:0]))
        else $error("Port A write did not update the output register.");

    // Serial A clock takes bit 1 whenever its internal clock runs.
    a_portb_clka: assert property (@(posedge clk)
        disable iff (!resetn)
        serialAClkEn |-> portBOut[1] == serialAClk && portBOe[1])
        else $error("Serial A clock not on port B bit 1.");

    // With both clocks off the low lines are released so pins can be read.
    a_portb_release: assert property (@(posedge clk)
        disable iff (!resetn)
        !serialBClkEn && !serialAClkEn |-> portBOe[1:0] == 2'b00)
        else $error("Port B bits 0 and 1 driven with serial clocks off.");

    // Without its function bit the pin follows the stored data bit.
    a_portc_data: assert property (@(posedge clk)
        disable iff (!resetn)
        !portCFunction[6] |-> portCOut[6] == portCData[6])
        else $error("Port C bit 6 does not follow its data bit.");

endmodule : ppabc_ports

`default_nettype wire

// ### ppabc_pin_model.sv
// Pin model: outside circuitry on the pins of ports A, B and C.
`timescale 1ns/1ps
`default_nettype none

module ppabc_pin_model (
    input wire logic [7:0] portAOut, // Port A drive.
    input wire logic [7:0] portAOe, // Port A enables.
    input wire logic [7:0] forceA, // Port A bits overpowered outside.
    input wire logic [7:0] extA, // Outside levels on port A.
    input wire logic [7:0] portBOut, // Port B drive.
    input wire logic [7:0] portBOe, // Port B enables.
    input wire logic [7:0] extB, // Outside levels on port B.
    input wire logic [7:0] portCOut, // Port C drive.
    input wire logic [7:0] portCOe, // Port C enables.
    input wire logic [7:0] extC, // Outside levels on port C.
    output logic [7:0] portAIn, // Port A pin levels.
    output logic [7:0] portBIn, // Port B pin levels.
    output logic [7:0] portCIn // Port C pin levels.
);
    // A strong outside source beats the port driver, so a read may differ
    // from the stored value; undriven lines take outside levels that the
    // bench redraws often, so a stale value never looks like a match.
    assign portAIn = (forceA & extA) |
        (~forceA & ((portAOe & portAOut) | (~portAOe & extA)));
    assign portBIn = (portBOe & portBOut) | (~portBOe & extB);
    assign portCIn = (portCOe & portCOut) | (~portCOe & extC);
endmodule : ppabc_pin_model
`default_nettype wire

// ### parallel_ports_abc_tb.sv
// Self-checking bench for ports A, B and C behind an APB slave.
`timescale 1ns/1ps
`default_nettype none

module parallel_ports_abc_tb;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, lastErr, slaveEnable;
    logic [7:0] portAIn, portAOut, portAOe, portBIn, portBOut, portBOe;
    logic [7:0] portCIn, portCOut, portCOe, d, f, p;
    logic [7:0] extA = 0, forceA = 0, extB = 0, extC = 0;
    logic [5:0] slaveBDrive = 0, slaveBOe = 0;
    logic serialAClk = 0, serialAClkEn = 0, serialBClk = 0;
    logic serialBClkEn = 0;
    logic [3:0] serialTx = 0, serialRx;
    logic [15:0] seed = 16'h004F;
    int n_fail = 0, tests_run = 0;

    // Free-running 40 MHz clock.
    always #12.5 clk = ~clk;

    ppabc_ports i_dut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portAIn(portAIn), .portAOut(portAOut),
        .portAOe(portAOe), .portBIn(portBIn), .portBOut(portBOut),
        .portBOe(portBOe), .slaveBDrive(slaveBDrive),
        .slaveBOe(slaveBOe), .slaveEnable(slaveEnable),
        .serialAClk(serialAClk), .serialAClkEn(serialAClkEn),
        .serialBClk(serialBClk), .serialBClkEn(serialBClkEn),
        .serialTx(serialTx), .portCIn(portCIn), .portCOut(portCOut),
        .portCOe(portCOe), .serialRx(serialRx));

    ppabc_pin_model i_pins (.portAOut(portAOut), .portAOe(portAOe),
        .forceA(forceA), .extA(extA), .portBOut(portBOut),
        .portBOe(portBOe), .extB(extB), .portCOut(portCOut),
        .portCOe(portCOe), .extC(extC), .portAIn(portAIn),
        .portBIn(portBIn), .portCIn(portCIn));

    // Sixteen-bit shift register gives repeatable random bytes.
    function automatic logic [7:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed[7:0];
    endfunction : rnd

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict

    // One APB transfer; only the watchdog ends a wait for pready.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // Redraw every outside level and every serial-side input.
    task shake;
        logic [7:0] a, b, c, e;
        a = rnd();
        b = rnd();
        c = rnd();
        e = rnd();
        @(posedge clk);
        extA <= a;
        forceA <= b & c;
        extB <= c;
        extC <= e;
        slaveBDrive <= a[7:2];
        slaveBOe <= b[5:0];
        {serialAClk, serialAClkEn, serialBClk, serialBClkEn} <= e[3:0];
        serialTx <= c[3:0] ^ e[7:4];
    endtask : shake

    function automatic logic [7:0] expA(input logic [7:0] v, input logic o);
        return (forceA & extA) | (~forceA & ({8{o}} & v | {8{~o}} & extA));
    endfunction : expA

    function automatic logic [7:0] pinB(input logic [7:0] w, input logic s);
        logic [7:0] dr, oe;
        dr = {w[7:6], 4'h0, serialAClk, serialBClk};
        oe = {2'b11, 4'h0, serialAClkEn, serialBClkEn};
        if (s) begin
            dr[7:2] = slaveBDrive;
            oe[7:2] = slaveBOe;
        end
        return (oe & dr) | (~oe & extB);
    endfunction : pinB

    function automatic logic [7:0] drvC(input logic [7:0] v, input logic [7:0] m);
        logic [7:0] tx;
        tx = {1'b0, serialTx[3], 1'b0, serialTx[2], 1'b0, serialTx[1],
            1'b0, serialTx[0]};
        return ((m & tx) | (~m & v)) & 8'h55;
    endfunction : drvC

    // Watchdog sized well above the few hundred cycles the run needs.
    initial begin
        #(25 * 5000);
        chk("watchdog", 0, 1);
        give_verdict();
    end

    // Main sequence: reset, then each port, then a reset in mid-run.
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1;
        @(negedge clk);
        chk("aOe", 0, portAOe);
        chk("bOut", 0, portBOut[7:6]);
        chk("cOut", 0, portCOut);
        for (int i = 0; i < 4; i++) begin
            shake();
            d = rnd();
            apb(1, ppabc_pkg::ADDR_PORT_A_DATA, d);
            apb(1, ppabc_pkg::ADDR_SLAVE_PORT_CONTROL, i[0] ?
                ppabc_pkg::SPC_PORT_A_OUTPUT : ppabc_pkg::SPC_PORT_A_INPUT);
            @(negedge clk);
            chk("aOe", {8{i[0]}}, portAOe);
            apb(0, ppabc_pkg::ADDR_PORT_A_DATA, 0);
            chk("aRead", expA(d, i[0]), rd);
            chk("aErr", 0, lastErr);
        end
        // Port B with the slave port off on even passes and on on odd passes.
        for (int i = 0; i < 8; i++) begin
            shake();
            d = rnd();
            apb(1, ppabc_pkg::ADDR_SLAVE_PORT_CONTROL, {7'h40, i[0]});
            apb(1, ppabc_pkg::ADDR_PORT_B_DATA, d);
            @(negedge clk);
            p = pinB(d, i[0]);
            chk("slvEn", i[0], slaveEnable);
            chk("bOe", {serialAClkEn, serialBClkEn}, portBOe[1:0]);
            chk("bOut", i[0] ? {slaveBDrive, 2'b00} : {d[7:6], 6'h00},
                portBOut & 8'hFC);
            apb(0, ppabc_pkg::ADDR_PORT_B_DATA, 0);
            chk("bRead", {i[0] ? slaveBDrive[5:4] : d[7:6], p[5:0]},
                rd);
        end
        for (int i = 0; i < 8; i++) begin
            shake();
            d = rnd();
            f = rnd();
            if (i < 4) f = 8'h01 << (2 * i);
            apb(1, ppabc_pkg::ADDR_PORT_C_DATA, d);
            apb(1, ppabc_pkg::ADDR_PORT_C_FUNCTION, f);
            @(negedge clk);
            chk("cOut", drvC(d, f), portCOut & 8'h55);
            chk("rx", {extC[7], extC[5], extC[3], extC[1]}, serialRx);
            chk("cOe", 8'h55, portCOe);
            apb(0, ppabc_pkg::ADDR_PORT_C_DATA, 0);
            chk("cRead", extC & 8'hAA | drvC(d, f), rd);
        end
        apb(0, ppabc_pkg::ADDR_PORT_C_FUNCTION, 0);
        chk("fnRead", 0, rd);
        apb(0, 12'h004, 0);
        chk("err", 1, lastErr);
        chk("errRd", 0, rd);
        apb(1, ppabc_pkg::ADDR_PORT_B_DATA, 32'h000000FF);
        apb(1, ppabc_pkg::ADDR_PORT_C_DATA, 32'h000000FF);
        apb(1, ppabc_pkg::ADDR_SLAVE_PORT_CONTROL, 32'h00000084);
        @(posedge clk);
        resetn <= 0;
        @(negedge clk);
        chk("aOe", 0, portAOe);
        chk("bOut", 0, portBOut[7:6]);
        chk("cOut", 0, portCOut & 8'h55);
        @(posedge clk);
        resetn <= 1;
        // The first transfer may start at the first edge after release.
        apb(0, ppabc_pkg::ADDR_SLAVE_PORT_CONTROL, 0);
        chk("spcRst", ppabc_pkg::SPC_RESET, rd);
        apb(0, ppabc_pkg::ADDR_PORT_B_DATA, 0);
        chk("bRst", 0, rd[7:6]);
        give_verdict();
    end
endmodule : parallel_ports_abc_tb
`default_nettype wire
